// file: bert_pkg.sv
// shared constants, types and helpers for the bit error rate tester
package bert_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_SEED = 8'h00;
  localparam logic [7:0] ADDR_LENGTH = 8'h04;
  localparam logic [7:0] ADDR_TAP = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_INJECT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_ERR_TOTAL = 8'h18;
  localparam logic [7:0] ADDR_BIT_TOTAL = 8'h1C;
  localparam logic [7:0] ADDR_RX_PATTERN = 8'h20;

  // pattern_control_reg fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_SYNC_EN_BIT = 1;
  localparam int CTRL_RESYNC_BIT = 2;
  localparam int CTRL_LATCH_BIT = 3;
  localparam int CTRL_LOAD_BIT = 7;

  // error_inject_reg fields
  localparam int INJ_RATE_LSB = 0;
  localparam int INJ_RATE_MSB = 2;
  localparam int INJ_SINGLE_BIT = 3;

  // status_reg fields
  localparam int STAT_SYNCED_BIT = 0;
  localparam int STAT_ONES_BIT = 1;
  localparam int STAT_ZEROS_BIT = 2;

  // reset values
  localparam logic [31:0] SEED_RST = 32'h0000_0000;
  localparam logic [4:0] LENGTH_RST = 5'h00;
  localparam logic [4:0] TAP_RST = 5'h00;
  localparam logic [2:0] RATE_RST = 3'h0;

  // sequencing counts
  localparam logic [6:0] SYNC_BASE_BITS = 7'h22;
  localparam logic [1:0] LOAD_EDGES = 2'h3;
  localparam logic [5:0] LOSS_WINDOW = 6'h3F;
  localparam logic [3:0] LOSS_ERRORS = 4'h6;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_LOAD = 3'b010,
    TX_RUN = 3'b100
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_SYNCED = 2'b10
  } rx_state_t;

  // ones in the low len+1 bits
  function automatic logic [31:0] len_mask(input logic [4:0] len);
    len_mask = 32'hFFFF_FFFF >> (5'h1F - len);
  endfunction : len_mask

  // next bit of the generator, tap a at len, tap b programmable
  function automatic logic fb_bit(input logic [31:0] sr, input logic [4:0] len,
                                  input logic [4:0] tap, input logic rep);
    fb_bit = rep ? sr[len] : (sr[len] ^ sr[tap]);
  endfunction : fb_bit

  // one shift of the pattern register, bits above the length kept clear
  function automatic logic [31:0] sr_step(input logic [31:0] sr, input logic [4:0] len,
                                          input logic [4:0] tap, input logic rep);
    sr_step = {sr[30:0], fb_bit(sr, len, tap, rep)} & len_mask(len);
  endfunction : sr_step

  // error period for rate code 1..7, zero means off
  function automatic logic [23:0] pow10(input logic [2:0] k);
    case (k)
      3'h1: pow10 = 24'h00000A;
      3'h2: pow10 = 24'h000064;
      3'h3: pow10 = 24'h0003E8;
      3'h4: pow10 = 24'h002710;
      3'h5: pow10 = 24'h0186A0;
      3'h6: pow10 = 24'h0F4240;
      3'h7: pow10 = 24'h989680;
      default: pow10 = 24'h000000;
    endcase
  endfunction : pow10

endpackage : bert_pkg

// file: bit_sync2.sv
// two flip-flop synchroniser for a group of independent pin levels
`timescale 1ns/1ps
module bit_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule : bit_sync2

// file: bit_error_rate_tester.sv
// bit error rate tester: pattern generator, checker, counters and apb registers
//
// Summary of operation
// - sync after 34 plus n clean bits
// - prbs checker tests bits against polynomial
// - repetitive checker matches same-length repeating pattern
// - count errors only while synced
// - sync enable and resync bits govern synchroniser
// - 32-bit error and bit counters
// - count latch delimits the integration period
// - inject single error or rate 1e-1..1e-7
// - tap a always at length minus one
// - tap b programmable to any position
// - repetitive patterns 1 to 32 bits
// - polynomial registers up to 32 bits
// - keep detection at one error per hundred
// - transmit and receive run independently
// - checker searches rx input for transmitted pattern
// - load rise; msb out after third tx edge
// - load pin ORed with soft load bit
// - register port, here an apb slave
`timescale 1ns/1ps
module bit_error_rate_tester (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // transmit link
  input wire logic tx_bit_clock_i,
  input wire logic transmit_load_i,
  output logic tx_data_o,
  // receive link
  input wire logic rx_bit_clock_i,
  input wire logic rx_data_i,
  input wire logic count_latch_i
);
  import bert_pkg::*;

  // synchronised pins: tx clock, load, rx clock, rx data, latch
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;

  bit_sync2 #(.WIDTH(5)) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i({tx_bit_clock_i, transmit_load_i, rx_bit_clock_i, rx_data_i, count_latch_i}),
    .sync_o(pin_sync)
  );

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_prev <= 5'h00;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  logic tx_rise;
  logic rx_rise;
  logic rx_bit;
  logic latch_pin_rise;
  assign tx_rise = pin_sync[4] & ~pin_prev[4];
  assign rx_rise = pin_sync[2] & ~pin_prev[2];
  assign rx_bit = pin_sync[1];
  assign latch_pin_rise = pin_sync[0] & ~pin_prev[0];

  // ---------------- register file ----------------
  logic [31:0] seed;
  logic [4:0] plen;
  logic [4:0] ptap;
  logic ctrl_mode;
  logic ctrl_sync_en;
  logic ctrl_load;
  logic [2:0] inj_rate;
  logic [31:0] next_seed;
  logic [4:0] next_plen;
  logic [4:0] next_ptap;
  logic next_ctrl_mode;
  logic next_ctrl_sync_en;
  logic next_ctrl_load;
  logic [2:0] next_inj_rate;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_commit;
  logic resync_pulse;
  logic latch_soft_pulse;
  logic single_pulse;

  // status read from receive side
  rx_state_t rx_state;
  logic [31:0] hist;
  logic [31:0] err_total;
  logic [31:0] bit_total;
  logic all_ones;
  logic all_zeros;
  assign all_ones = (hist & len_mask(plen)) == len_mask(plen);
  assign all_zeros = (hist & len_mask(plen)) == 32'h0000_0000;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= ADDR_RX_PATTERN) && (a[1:0] == 2'h0);
  endfunction : addr_ok

  // apb slave decode
  // answer one cycle into the access phase; write lands at the completing edge
  always_comb begin
    next_seed = seed;
    next_plen = plen;
    next_ptap = ptap;
    next_ctrl_mode = ctrl_mode;
    next_ctrl_sync_en = ctrl_sync_en;
    next_ctrl_load = ctrl_load;
    next_inj_rate = inj_rate;
    next_prdata = prdata_o;
    next_pready = psel_i & penable_i & ~pready_o;
    next_pslverr = 1'b0;
    wr_commit = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
    resync_pulse = 1'b0;
    latch_soft_pulse = 1'b0;
    single_pulse = 1'b0;
    if (psel_i & penable_i & ~pready_o) begin
      next_pslverr = ~addr_ok(paddr_i);
      next_prdata = 32'h0000_0000;
      if (!pwrite_i) begin
        case (paddr_i)
          ADDR_SEED: next_prdata = seed;
          ADDR_LENGTH: next_prdata = {27'h0000000, plen};
          ADDR_TAP: next_prdata = {27'h0000000, ptap};
          ADDR_CONTROL: next_prdata = {24'h000000, ctrl_load, 5'h00, ctrl_sync_en, ctrl_mode};
          ADDR_INJECT: next_prdata = {29'h00000000, inj_rate};
          ADDR_STATUS: next_prdata = {29'h00000000, all_zeros, all_ones, rx_state == RX_SYNCED};
          ADDR_ERR_TOTAL: next_prdata = err_total;
          ADDR_BIT_TOTAL: next_prdata = bit_total;
          ADDR_RX_PATTERN: next_prdata = hist;
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_commit) begin
      case (paddr_i)
        ADDR_SEED: next_seed = pwdata_i;
        ADDR_LENGTH: next_plen = pwdata_i[4:0];
        ADDR_TAP: next_ptap = pwdata_i[4:0];
        ADDR_CONTROL: begin
          next_ctrl_mode = pwdata_i[CTRL_MODE_BIT];
          next_ctrl_sync_en = pwdata_i[CTRL_SYNC_EN_BIT];
          next_ctrl_load = pwdata_i[CTRL_LOAD_BIT];
          resync_pulse = pwdata_i[CTRL_RESYNC_BIT];
          latch_soft_pulse = pwdata_i[CTRL_LATCH_BIT];
        end
        ADDR_INJECT: begin
          next_inj_rate = pwdata_i[INJ_RATE_MSB:INJ_RATE_LSB];
          single_pulse = pwdata_i[INJ_SINGLE_BIT];
        end
        default: next_seed = seed;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      seed <= SEED_RST;
      plen <= LENGTH_RST;
      ptap <= TAP_RST;
      ctrl_mode <= 1'b0;
      ctrl_sync_en <= 1'b0;
      ctrl_load <= 1'b0;
      inj_rate <= RATE_RST;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      seed <= next_seed;
      plen <= next_plen;
      ptap <= next_ptap;
      ctrl_mode <= next_ctrl_mode;
      ctrl_sync_en <= next_ctrl_sync_en;
      ctrl_load <= next_ctrl_load;
      inj_rate <= next_inj_rate;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end

  // ---------------- transmit generator ----------------
  // own tx clock; shares the length, tap and mode registers with receive
  tx_state_t tx_state;
  tx_state_t next_tx_state;
  logic [1:0] load_cnt;
  logic [1:0] next_load_cnt;
  logic [31:0] gen;
  logic [31:0] next_gen;
  logic [23:0] inj_cnt;
  logic [23:0] next_inj_cnt;
  logic single_pend;
  logic next_single_pend;
  logic load_prev;
  logic next_tx_data;
  logic load_level;
  logic load_rise;
  logic inject_now;
  logic bit_out;

  // pin and soft bit ORed before edge detection
  assign load_level = pin_sync[3] | ctrl_load;
  assign load_rise = load_level & ~load_prev;

  // single or 1 in 10^k; >= so a count left from a slower rate never waits for the wrap
  assign inject_now = single_pend | ((inj_rate != 3'h0) && (inj_cnt >= pow10(inj_rate) - 24'h000001));

  always_comb begin
    next_tx_state = tx_state;
    next_load_cnt = load_cnt;
    next_gen = gen;
    next_inj_cnt = inj_cnt;
    next_tx_data = tx_data_o;
    bit_out = 1'b0;
    // a single request arriving as one is consumed is kept
    next_single_pend = single_pend | single_pulse;
    if (load_rise) begin
      next_tx_state = TX_LOAD;
      next_load_cnt = 2'h0;
    end else if (tx_rise) begin
      case (tx_state)
        TX_LOAD: begin
          next_load_cnt = load_cnt + 2'h1;
          if (load_cnt == LOAD_EDGES - 2'h1) begin
            // msb leaves on the third edge
            next_gen = seed & len_mask(plen);
            next_tx_data = seed[plen] ^ inject_now;
            next_tx_state = TX_RUN;
            bit_out = 1'b1;
          end
        end
        TX_RUN: begin
          // tap a at length-1, tap b programmable
          next_gen = sr_step(gen, plen, ptap, ctrl_mode);
          next_tx_data = next_gen[plen] ^ inject_now;
          bit_out = 1'b1;
        end
        default: next_tx_data = 1'b0;
      endcase
    end
    if (bit_out) begin
      // rate counter advances per transmitted bit
      next_inj_cnt = inject_now ? 24'h000000 : inj_cnt + 24'h000001;
      next_single_pend = single_pulse;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_state <= TX_IDLE;
      load_cnt <= 2'h0;
      gen <= 32'h0000_0000;
      inj_cnt <= 24'h000000;
      single_pend <= 1'b0;
      load_prev <= 1'b0;
      tx_data_o <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      load_cnt <= next_load_cnt;
      gen <= next_gen;
      inj_cnt <= next_inj_cnt;
      single_pend <= next_single_pend;
      load_prev <= load_level;
      tx_data_o <= next_tx_data;
    end
  end

  // ---------------- receive checker and counters ----------------
  rx_state_t next_rx_state;
  logic [31:0] ref_sr;
  logic [31:0] next_ref_sr;
  logic [31:0] next_hist;
  logic [6:0] good_cnt;
  logic [6:0] next_good_cnt;
  logic [5:0] win_cnt;
  logic [5:0] next_win_cnt;
  logic [3:0] win_err;
  logic [3:0] next_win_err;
  logic [31:0] err_run;
  logic [31:0] next_err_run;
  logic [31:0] bit_run;
  logic [31:0] next_bit_run;
  logic [31:0] next_err_total;
  logic [31:0] next_bit_total;
  logic expected;
  logic miss;
  logic latch_ev;
  logic count_bit;
  logic count_err;

  // prediction from the transmit polynomial or the repeat length
  assign expected = fb_bit(ref_sr, plen, ptap, ctrl_mode);
  assign miss = rx_bit != expected;
  // pin edge or soft strobe ends the period
  assign latch_ev = latch_pin_rise | latch_soft_pulse;

  always_comb begin
    next_rx_state = rx_state;
    next_ref_sr = ref_sr;
    next_hist = hist;
    next_good_cnt = good_cnt;
    next_win_cnt = win_cnt;
    next_win_err = win_err;
    count_bit = 1'b0;
    count_err = 1'b0;
    if (rx_rise) begin
      next_hist = {hist[30:0], rx_bit};
      case (rx_state)
        RX_HUNT: begin
          // hunting: prediction seeded from received bits
          next_ref_sr = {ref_sr[30:0], rx_bit} & len_mask(plen);
          next_good_cnt = miss ? 7'h00 : (good_cnt == 7'h7F ? good_cnt : good_cnt + 7'h01);
          if (ctrl_sync_en && !miss && good_cnt == SYNC_BASE_BITS + {2'h0, plen}) begin
            next_rx_state = RX_SYNCED;
            next_win_cnt = 6'h00;
            next_win_err = 4'h0;
          end
        end
        RX_SYNCED: begin
          // free-running reference, so one line error counts once
          next_ref_sr = {ref_sr[30:0], expected} & len_mask(plen);
          count_bit = 1'b1;
          // deviation while synced is an error
          count_err = miss;
          // loss needs six errors in 64 bits, far above 1e-2
          next_win_cnt = win_cnt + 6'h01;
          next_win_err = win_err + {3'h0, miss};
          if (win_err + {3'h0, miss} >= LOSS_ERRORS) begin
            next_rx_state = RX_HUNT;
            next_good_cnt = 7'h00;
          end else if (win_cnt == LOSS_WINDOW) begin
            next_win_err = 4'h0;
          end
        end
        default: next_rx_state = RX_HUNT;
      endcase
    end
    if (resync_pulse || !ctrl_sync_en) begin
      next_rx_state = RX_HUNT;
      // clean run counts only while enabled, else it overshoots the exact-match sync test
      next_good_cnt = 7'h00;
    end
    // running totals, bit in the latch cycle goes to the snapshot
    next_err_run = err_run + {31'h00000000, count_err};
    next_bit_run = bit_run + {31'h00000000, count_bit};
    next_err_total = err_total;
    next_bit_total = bit_total;
    if (latch_ev) begin
      next_err_total = next_err_run;
      next_bit_total = next_bit_run;
      next_err_run = 32'h0000_0000;
      next_bit_run = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_state <= RX_HUNT;
      ref_sr <= 32'h0000_0000;
      hist <= 32'h0000_0000;
      good_cnt <= 7'h00;
      win_cnt <= 6'h00;
      win_err <= 4'h0;
      err_run <= 32'h0000_0000;
      bit_run <= 32'h0000_0000;
      err_total <= 32'h0000_0000;
      bit_total <= 32'h0000_0000;
    end else begin
      rx_state <= next_rx_state;
      ref_sr <= next_ref_sr;
      hist <= next_hist;
      good_cnt <= next_good_cnt;
      win_cnt <= next_win_cnt;
      win_err <= next_win_err;
      err_run <= next_err_run;
      bit_run <= next_bit_run;
      err_total <= next_err_total;
      bit_total <= next_bit_total;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  chk_sync_clean_run: assert property (
    (rx_state == RX_HUNT) ##1 (rx_state == RX_SYNCED) |-> $past(good_cnt) == SYNC_BASE_BITS + {2'h0, plen})
    else $error("sync declared after wrong clean run");
  chk_error_counts: assert property (
    rx_rise && rx_state == RX_SYNCED && miss && !latch_ev && !resync_pulse |=> err_run == $past(err_run) + 32'h1)
    else $error("synced error not counted");
  chk_hunt_no_count: assert property (
    rx_state == RX_HUNT && !latch_ev |=> err_run == $past(err_run) && bit_run == $past(bit_run))
    else $error("counting while not synced");
  chk_latch_restart: assert property (
    latch_ev |=> err_run == 32'h0 && bit_run == 32'h0 && err_total == $past(err_run) + {31'h0, $past(count_err)}
      && bit_total == $past(bit_run) + {31'h0, $past(count_bit)})
    else $error("latch did not move totals");
  chk_resync_drop: assert property (
    resync_pulse |=> rx_state == RX_HUNT && good_cnt == 7'h00)
    else $error("resync did not drop lock");
  chk_load_starts: assert property (
    load_rise |=> tx_state == TX_LOAD && load_cnt == 2'h0)
    else $error("load edge ignored");
  chk_third_edge_msb: assert property (
    tx_state == TX_LOAD && tx_rise && !load_rise && load_cnt == 2'h2 |=> tx_state == TX_RUN && tx_data_o == ($past(seed[plen]) ^ $past(inject_now)))
    else $error("msb not out on third edge");
  chk_rep_tap_a: assert property (
    tx_state == TX_RUN && tx_rise && !load_rise && ctrl_mode |=> gen[0] == $past(gen[plen]))
    else $error("repetitive feedback not from tap a");
  chk_single_used: assert property (
    single_pend && tx_state == TX_RUN && tx_rise && !load_rise && !single_pulse |=> !single_pend && tx_data_o != gen[plen])
    else $error("single error not inserted");
  chk_apb_answer: assert property (
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("apb answer not one cycle");

  cover_sync_reached: cover property ((rx_state == RX_HUNT) ##1 (rx_state == RX_SYNCED));
  cover_error_counted: cover property (count_err && rx_state == RX_SYNCED);
  cover_load_run: cover property ((tx_state == TX_LOAD) ##1 (tx_state == TX_RUN));
  cover_latch: cover property (latch_ev && err_run != 32'h0);

endmodule : bit_error_rate_tester

// file: link_far_end.sv
// far-end equipment model: link clocks and a loopback with bit corruption
`timescale 1ns/1ps
module link_far_end (
  // link clocks
  output logic tx_clk_o,
  output logic rx_clk_o,
  // loopback path
  input wire logic tx_data_i,
  input wire logic flip_i,
  output logic rx_data_o
);
  // free-running clocks; rx lags so the looped bit has settled
  // separate clocks
  // one process drives every output, the loopback thread included
  initial begin
    tx_clk_o = 1'b0;
    rx_clk_o = 1'b0;
    rx_data_o = 1'b0;
    #1.3;
    fork
      forever #62.5 tx_clk_o = ~tx_clk_o;
      begin
        #30;
        forever #62.5 rx_clk_o = ~rx_clk_o;
      end
      // same pattern back, moved on the falling edge, away from sampling
      forever @(negedge rx_clk_o) rx_data_o <= tx_data_i ^ flip_i;
    join
  end
endmodule : link_far_end

// file: bit_error_rate_tester_test.sv
// self-checking bench for the bit error rate tester, looped back through the far end
`timescale 1ns/1ps
module bit_error_rate_tester_test;
  import bert_pkg::*;
  logic sys_clk, reset, psel, penable, pwrite, load_pin, latch_pin, flip;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, tx_clk, rx_clk, tx_data, rx_data;
  int error_cnt = 0;
  int checks = 0;

  // design and far-end model
  bit_error_rate_tester uut (.sys_clk_i(sys_clk), .reset_i(reset), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_bit_clock_i(tx_clk), .transmit_load_i(load_pin), .tx_data_o(tx_data),
    .rx_bit_clock_i(rx_clk), .rx_data_i(rx_data), .count_latch_i(latch_pin));
  link_far_end peer (.tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .tx_data_i(tx_data), .flip_i(flip),
    .rx_data_o(rx_data));

  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic fail(input string msg);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fail

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask : check_val

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge sys_clk);
    // select held through the whole access
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail("apb hang");
      complete_run();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check_val(q, exp, what);
  endtask : rd_chk

  task automatic rx_bits(input int k);
    repeat (k) @(negedge rx_clk);
  endtask : rx_bits

  // pin latch placed mid-bit, far from the sampling rise
  task automatic pin_latch();
    @(negedge rx_clk);
    @(posedge sys_clk);
    latch_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    latch_pin <= 1'b0;
  endtask : pin_latch

  task automatic s_regs();
    logic [31:0] q;
    logic e;
    for (int a = 0; a < 36; a += 4) begin
      if (a != 20 && a != 32) rd_chk(8'(a), 32'h0, "reset value");
    end
    wr(ADDR_LENGTH, 32'hFFFF_FFFF);
    rd_chk(ADDR_LENGTH, 32'h0000_001F, "length field");
    wr(ADDR_ERR_TOTAL, 32'h0000_00FF);
    rd_chk(ADDR_ERR_TOTAL, 32'h0, "read-only total");
    apb(1'b0, 8'h24, 32'h0, q, e);
    check_val({31'h0, e}, 32'h1, "unmapped");
    apb(1'b1, 8'h06, 32'h0, q, e);
    check_val({31'h0, e}, 32'h1, "unaligned");
    rx_bits(40);
    rd_chk(ADDR_STATUS, 32'h4, "zeros flag");
  endtask : s_regs

  // msb of a repetitive seed after the third tx rise
  task automatic s_load();
    logic [4:0] want;
    want = 5'b10100;
    wr(ADDR_SEED, 32'h0000_00A5);
    wr(ADDR_LENGTH, 32'h0000_0007);
    wr(ADDR_CONTROL, 32'h0000_0001);
    check_val({31'h0, tx_data}, 32'h0, "tx before load");
    @(negedge tx_clk);
    @(posedge sys_clk);
    load_pin <= 1'b1;
    for (int i = 1; i <= 5; i++) begin
      @(posedge tx_clk);
      repeat (10) @(posedge sys_clk);
      if (i >= 3) check_val({31'h0, tx_data}, {31'h0, want[i-1]}, "tx bit");
    end
    load_pin <= 1'b0;
  endtask : s_load

  task automatic s_rep();
    logic [31:0] q;
    logic e;
    wr(ADDR_CONTROL, 32'h3);
    rx_bits(40);
    rd_chk(ADDR_STATUS, 32'h0, "early sync");
    // ones among the first eight pattern bits miss against the old zeros, so the clean run starts late
    rx_bits(12);
    rd_chk(ADDR_STATUS, 32'h1, "rep sync");
    apb(1'b0, ADDR_RX_PATTERN, 32'h0, q, e);
    e = 1'b0;
    for (int r = 0; r < 8; r++) begin
      if (q === (({4{8'hA5}} >> r) | ({4{8'hA5}} << (32 - r)))) e = 1'b1;
    end
    check_val({31'h0, e}, 32'h1, "rx pattern");
    wr(ADDR_CONTROL, 32'h1);
    rd_chk(ADDR_STATUS, 32'h0, "sync disabled");
    wr(ADDR_CONTROL, 32'h3);
    rx_bits(50);
    wr(ADDR_CONTROL, 32'h7);
    rd_chk(ADDR_STATUS, 32'h0, "resync");
    rx_bits(50);
    rd_chk(ADDR_STATUS, 32'h1, "resynced");
  endtask : s_rep

  // three line errors inside a 40-bit integration period
  task automatic s_count();
    pin_latch();
    for (int j = 0; j < 3; j++) begin
      rx_bits(10);
      @(posedge sys_clk);
      flip <= 1'b1;
      rx_bits(1);
      @(posedge sys_clk);
      flip <= 1'b0;
    end
    rx_bits(7);
    wr(ADDR_CONTROL, 32'hB);
    rd_chk(ADDR_ERR_TOTAL, 32'h3, "error total");
    rd_chk(ADDR_BIT_TOTAL, 32'd40, "bit total");
    rd_chk(ADDR_STATUS, 32'h1, "still synced");
  endtask : s_count

  task automatic s_prbs();
    logic [31:0] q;
    logic e;
    int n;
    // every pattern register written before the load
    wr(ADDR_LENGTH, 32'h6);
    wr(ADDR_TAP, 32'h5);
    wr(ADDR_SEED, 32'h55);
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_CONTROL, 32'h82);
    n = 0;
    do begin
      rx_bits(4);
      apb(1'b0, ADDR_STATUS, 32'h0, q, e);
      n++;
    end while (q !== 32'h1 && n < 40);
    check_val(q, 32'h1, "prbs sync");
    pin_latch();
    wr(ADDR_INJECT, 32'h8);
    rx_bits(30);
    wr(ADDR_CONTROL, 32'h8A);
    rd_chk(ADDR_ERR_TOTAL, 32'h1, "single inject");
    wr(ADDR_INJECT, 32'h2);
    rx_bits(300);
    wr(ADDR_CONTROL, 32'h8A);
    wr(ADDR_INJECT, 32'h0);
    apb(1'b0, ADDR_ERR_TOTAL, 32'h0, q, e);
    check_val({31'h0, q >= 2 && q <= 4}, 32'h1, "rate inject");
  endtask : s_prbs

  // main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    load_pin = 1'b0;
    latch_pin = 1'b0;
    flip = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    s_regs();
    s_load();
    s_rep();
    s_count();
    s_prbs();
    complete_run();
  end

  // cut a hung run short
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail("watchdog");
    complete_run();
  end
endmodule : bit_error_rate_tester_test
